/* File: core/hfadc_pkg.sv */
// Package for the half-flash converter host controller
package hfadc_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int SETUP_NS = 500;
    localparam int FAST_RD_NS = 600;
    localparam int CONV_NS = 700;
    localparam int WR_LOW_NS = 600;
    localparam int ACCESS_NS = 250;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAST_RD_CYC = (FAST_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_LOW_CYC = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_CYC = 1024;
    localparam int CNT_W = 11;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_DATA = 4'h8;
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_FAST = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_OVR = 2;
    localparam int STAT_TMO = 3;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    typedef enum logic [2:0] {
        HF_IDLE = 3'b000,
        HF_GAP = 3'b001,
        HF_WR_LOW = 3'b010,
        HF_WAIT = 3'b011,
        HF_RD = 3'b100,
        HF_RO_RD = 3'b101
    } hfadc_state_t;
endpackage : hfadc_pkg

/* File: core/hfadc_host.sv */
// Host controller driving a half-flash ADC through its pins
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module hfadc_host
    import hfadc_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter pins
    output logic cs_n_o,
    output logic rd_n_o,
    output logic mode_o,
    output logic wr_n_o,
    output logic wr_n_oe_o,
    input wire logic rdy_n_i,
    input wire logic int_n_i,
    input wire logic overrange_n_i,
    input wire logic [7:0] result_bus_i
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [10:0] sync1;
    logic [10:0] sync2;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 11'h7FF;
            sync2 <= 11'h7FF;
        end else if (ce_i) begin
            sync1 <= {rdy_n_i, int_n_i, overrange_n_i, result_bus_i};
            sync2 <= sync1;
        end
    end
    logic rdy_n_s;
    logic int_n_s;
    logic ovr_n_s;
    logic [7:0] bus_s;
    assign rdy_n_s = sync2[10];
    assign int_n_s = sync2[9];
    assign ovr_n_s = sync2[8];
    assign bus_s = sync2[7:0];

    // ****************************************
    // Registers over Wishbone
    // ****************************************
    logic req;
    logic mode;
    logic fast;
    logic busy;
    logic done;
    logic ovr;
    logic tmo;
    logic [7:0] result;
    logic start_pulse;
    logic finish;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign start_pulse = ce_i && req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_CTRL)
                         && wb_dat_i[CTRL_START] && !busy;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= ZERO_WORD;
        end else if (ce_i) begin
            wb_ack_o <= req;
            wb_dat_o <= ZERO_WORD;
            if (req && !wb_we_i) begin
                unique case (wb_adr_i)
                    ADDR_CTRL: wb_dat_o <= {29'h0, fast, mode, 1'b0};
                    ADDR_STAT: wb_dat_o <= {28'h0, tmo, ovr, done, busy};
                    ADDR_DATA: wb_dat_o <= {24'h0, result};
                    default: wb_dat_o <= ZERO_WORD;
                endcase
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= 1'b1;
            fast <= 1'b0;
        end else if (ce_i && req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL && !busy) begin
            mode <= wb_dat_i[CTRL_MODE];
            fast <= wb_dat_i[CTRL_FAST];
        end
    end
    // Done: set wins over clear by a status read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done <= 1'b0;
        end else if (ce_i) begin
            if (finish) begin
                done <= 1'b1;
            end else if (req && !wb_we_i && wb_adr_i == ADDR_STAT) begin
                done <= 1'b0;
            end
        end
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    hfadc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gap;
    function automatic logic [CNT_W-1:0] cyc_of(input int n);
        cyc_of = CNT_W'(n);
    endfunction : cyc_of
    assign busy = (state != HF_IDLE);
    // Only a completed read finishes; a timeout never latches a result
    assign finish = ce_i && (state == HF_RD) && (cnt == CNT_ONE);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= HF_IDLE;
            cnt <= CNT_ZERO;
            cs_n_o <= 1'b1;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            tmo <= 1'b0;
        end else if (ce_i) begin
            if (cnt != CNT_ZERO) begin
                cnt <= cnt - CNT_ONE;
            end
            unique case (state)
                HF_IDLE: begin
                    if (start_pulse) begin
                        tmo <= 1'b0;
                        state <= HF_GAP;
                    end
                end
                HF_GAP: begin
                    if (gap == CNT_ZERO) begin
                        cs_n_o <= 1'b0;
                        if (mode) begin
                            wr_n_o <= 1'b0;
                            cnt <= cyc_of(WR_LOW_CYC);
                            state <= HF_WR_LOW;
                        end else begin
                            rd_n_o <= 1'b0;
                            cnt <= cyc_of(TIMEOUT_CYC);
                            state <= HF_RO_RD;
                        end
                    end
                end
                HF_WR_LOW: begin
                    if (cnt == CNT_ZERO) begin
                        wr_n_o <= 1'b1;
                        cnt <= fast ? cyc_of(FAST_RD_CYC) : cyc_of(TIMEOUT_CYC);
                        state <= HF_WAIT;
                    end
                end
                HF_WAIT: begin
                    if ((fast && cnt == CNT_ZERO) || (!fast && !int_n_s)) begin
                        rd_n_o <= 1'b0;
                        cnt <= cyc_of(ACCESS_CYC + 2);
                        state <= HF_RD;
                    end else if (!fast && cnt == CNT_ZERO) begin
                        tmo <= 1'b1;
                        cs_n_o <= 1'b1;
                        state <= HF_IDLE;
                    end
                end
                HF_RO_RD: begin
                    if (rdy_n_s && cnt < cyc_of(TIMEOUT_CYC - 4)) begin
                        cnt <= cyc_of(ACCESS_CYC + 2);
                        state <= HF_RD;
                    end else if (cnt == CNT_ZERO) begin
                        tmo <= 1'b1;
                        cs_n_o <= 1'b1;
                        rd_n_o <= 1'b1;
                        state <= HF_IDLE;
                    end
                end
                HF_RD: begin
                    if (cnt == CNT_ONE) begin
                        rd_n_o <= 1'b1;
                        cs_n_o <= 1'b1;
                        state <= HF_IDLE;
                    end
                end
                default: state <= HF_IDLE;
            endcase
        end
    end
    // Read-to-write spacing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap <= CNT_ZERO;
        end else if (ce_i) begin
            if (finish) begin
                gap <= cyc_of(SETUP_CYC);
            end else if (gap != CNT_ZERO) begin
                gap <= gap - CNT_ONE;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result <= 8'h00;
            ovr <= 1'b0;
        end else if (finish) begin
            result <= bus_s;
            ovr <= !ovr_n_s;
        end
    end
    assign mode_o = mode;
    assign wr_n_oe_o = mode;

    // ****************************************
    // Assertions
    // ****************************************
    property p_gap;
        @(posedge clk_i) disable iff (rst_i)
        finish |=> (gap == cyc_of(SETUP_CYC));
    endproperty
    a_gap: assert property (p_gap) else $error("read-to-write gap not loaded");
    property p_wrgap;
        @(posedge clk_i) disable iff (rst_i)
        $fell(wr_n_o) |-> $past(gap) == CNT_ZERO;
    endproperty
    a_wrgap: assert property (p_wrgap) else $error("write started inside read-to-write gap");
    property p_wrlow;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && $fell(wr_n_o) |=> !wr_n_o [*8];
    endproperty
    a_wrlow: assert property (p_wrlow) else $error("write pulse too short");
    property p_fast;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rd_n_o) && mode |-> $past(state) == HF_WAIT;
    endproperty
    a_fast: assert property (p_fast) else $error("read before wait");
    property p_sel;
        @(posedge clk_i) disable iff (rst_i)
        (!rd_n_o || !wr_n_o) |-> !cs_n_o;
    endproperty
    a_sel: assert property (p_sel) else $error("strobe without select");
    property p_ro;
        @(posedge clk_i) disable iff (rst_i)
        !mode_o && busy |-> wr_n_o;
    endproperty
    a_ro: assert property (p_ro) else $error("write in read-only mode");
    property p_oe;
        @(posedge clk_i) disable iff (rst_i)
        busy && $past(busy) |-> wr_n_oe_o == mode_o && $stable(mode_o);
    endproperty
    a_oe: assert property (p_oe) else $error("ready pin driven");
    property p_fin;
        @(posedge clk_i) disable iff (rst_i)
        finish |=> rd_n_o && cs_n_o && done;
    endproperty
    a_fin: assert property (p_fin) else $error("read not released");
    property p_rohold;
        @(posedge clk_i) disable iff (rst_i)
        state == HF_RO_RD |-> !rd_n_o && !cs_n_o;
    endproperty
    a_rohold: assert property (p_rohold) else $error("read released before ready");
    property p_intwait;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rd_n_o) && mode_o && !fast |-> !$past(int_n_s);
    endproperty
    a_intwait: assert property (p_intwait) else $error("read before completion");
    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && req |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus not acked");
    c_wr: cover property (@(posedge clk_i) $rose(wr_n_o) && mode_o);
    c_ro: cover property (@(posedge clk_i) finish && !mode_o);
    c_fast: cover property (@(posedge clk_i) finish && fast);
    c_tmo: cover property (@(posedge clk_i) $rose(tmo));
    c_ovr: cover property (@(posedge clk_i) finish && !ovr_n_s);
endmodule : hfadc_host
`default_nettype wire

/* File: tb/hfadc_dev_model.sv */
// Behavioural model of the half-flash converter pins
`timescale 1ns/1ns
`default_nettype none
module hfadc_dev_model (
    // Host strobes
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic mode_i,
    input wire logic wr_n_i,
    // Analog stand-in and knobs
    input wire logic [7:0] ain_i,
    input wire logic ovr_i,
    input wire logic slow_i,
    input wire logic mute_i,
    // Device outputs
    output logic rdy_low_o,
    output logic int_n_o,
    output logic ovr_n_o,
    output logic [7:0] bus_o,
    output logic [7:0] viol_o
);
    logic [7:0] res = 8'h00;
    logic busy = 1'b0;
    logic rd_act = 1'b0;
    realtime t_rd = -1000.0;
    realtime t_wr = 0.0;
    // Completion count, so a late timer of an ended conversion stays quiet
    int conv_id = 0;
    int wr_id = 0;
    initial begin
        rdy_low_o = 1'b0;
        int_n_o = 1'b1;
        ovr_n_o = 1'b1;
        viol_o = 8'h00;
    end
    // Released bus shows the inverse
    assign bus_o = (!cs_n_i && !rd_n_i && !busy) ? res : ~res;
    task automatic done_conv();
        int_n_o = 1'b0;
        ovr_n_o = !ovr_i;
        rdy_low_o = 1'b0;
        busy = 1'b0;
        conv_id++;
    endtask : done_conv
    always @(negedge wr_n_i) if (mode_i && !cs_n_i) begin
        if ($realtime - t_rd < 500) viol_o++;
        busy = 1'b1;
    end
    always @(posedge wr_n_i) if (mode_i && !cs_n_i && busy) begin
        t_wr = $realtime;
        wr_id = conv_id;
        #100 res = ain_i;
        #(slow_i ? 1300 : 600);
        if (busy && !mute_i && wr_id == conv_id) done_conv();
    end
    always @(negedge rd_n_i) if (!cs_n_i) begin
        rd_act = 1'b1;
        if (mode_i) begin
            if ($realtime - t_wr < 600) viol_o++;
            if (busy && !mute_i) begin
                res = ain_i;
                done_conv();
            end
        end else begin
            busy = 1'b1;
            int_n_o = 1'b1;
            rdy_low_o = 1'b1;
            #600 res = ain_i;
            #(slow_i ? 1000 : 400);
            done_conv();
        end
    end
    always @(posedge rd_n_i or posedge cs_n_i) begin
        if (busy && !mode_i) viol_o++;
        if (rd_act) t_rd = $realtime;
        rd_act = 1'b0;
        int_n_o = 1'b1;
    end
endmodule : hfadc_dev_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the half-flash converter host controller
`timescale 1ns/1ns
`default_nettype none
module testbench
    import hfadc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, cs_n_o, rd_n_o, mode_o, wr_n_o, wr_n_oe_o, rdy_low, int_n, ovr_n;
    logic [7:0] bus, viol, ain = 8'h00;
    logic ovr = 1'b0, slow = 1'b0, mute = 1'b0;
    logic [31:0] exp_q[$], msk_q[$];
    int n_mismatch = 0, n_compared = 0, seed = 95070;
    logic [31:0] mk;
    logic [7:0] last_v = 8'h00;
    wire logic pin;
    // Shared write/ready pin, released ready reads high
    assign pin = wr_n_oe_o ? wr_n_o : !rdy_low;
    always #2 clk_i = ~clk_i;
    hfadc_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .mode_o(mode_o), .wr_n_o(wr_n_o),
        .wr_n_oe_o(wr_n_oe_o), .rdy_n_i(pin), .int_n_i(int_n), .overrange_n_i(ovr_n), .result_bus_i(bus));
    hfadc_dev_model dev_u (.cs_n_i(cs_n_o), .rd_n_i(rd_n_o), .mode_i(mode_o), .wr_n_i(pin), .ain_i(ain),
        .ovr_i(ovr), .slow_i(slow), .mute_i(mute), .rdy_low_o(rdy_low), .int_n_o(int_n), .ovr_n_o(ovr_n),
        .bus_o(bus), .viol_o(viol));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        if (n >= 64) n_mismatch++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_cycle
    task automatic rd(input logic [3:0] adr, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        wb_cycle(1'b0, adr, 32'h0);
    endtask : rd
    task automatic convert(input logic [31:0] ctrl, input logic [7:0] v, input logic ov, input logic sl);
        int n;
        n = 0;
        ain <= v;
        ovr <= ov;
        slow <= sl;
        wb_cycle(1'b1, ADDR_CTRL, ctrl);
        // Flipped mode must be ignored while busy
        wb_cycle(1'b1, ADDR_CTRL, ctrl ^ 32'h3);
        while (cs_n_o !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        while (cs_n_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) n_mismatch++;
        repeat (2) @(posedge clk_i);
        rd(ADDR_STAT, mute ? 32'h8 : {29'h0, ov, 2'b10}, mute ? 32'hB : 32'hF);
        rd(ADDR_DATA, {24'h0, mute ? last_v : v}, 32'hFF);
        rd(ADDR_CTRL, ctrl & 32'h6, 32'h7);
        if (!mute) last_v = v;
    endtask : convert
    // Oldest note against each read answer
    always @(posedge clk_i) if (wb_ack_o === 1'b1 && !wb_we_i) begin
        if (exp_q.size() > 0) begin
            mk = msk_q.pop_front();
            cmp_word(wb_dat_o & mk, exp_q.pop_front() & mk);
        end
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ADDR_STAT, 32'h0, 32'hF);
        rd(4'hC, 32'h0, 32'hFFFF_FFFF);
        convert(32'h3, 8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 12; i++) begin
            convert(i % 3 == 1 ? 32'h7 : (i % 3 == 2 ? 32'h1 : 32'h3), 8'($random(seed)), i % 4 == 3, i > 5);
        end
        mute <= 1'b1;
        convert(32'h3, 8'h5A, 1'b0, 1'b0);
        cmp_word({24'h0, viol}, 32'h0);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
